/* File: include/lcm_pkg.sv */
// package for the line channel mode control register bank
// assumes an apb slave with 32-bit data, one aligned word per channel register
//
// Summary of operation
// RULE_01: the two loop-back select bits decode as none, remote, analog local or digital local loop-back.
// RULE_02: both loop-back select bits are read/write and reset to zero, so no loop-back is active after reset.
// RULE_03: with the e3 select bit set the channel runs at e3 rate and the sonet select bit is ignored.
// RULE_04: with e3 select and sonet select both zero the channel runs in ds3 mode.
// RULE_05: with e3 select zero and sonet select one the channel runs in sts-1 mode.
// RULE_06: e3 select at bit 2 and sonet select at bit 1 are read/write and reset to zero, giving ds3.
// RULE_07: the rail format bit at bit 0 is read/write, resets to zero and picks single or dual rail.
// RULE_08: in single-rail operation the line encoder and decoder of the channel are both active.
// RULE_09: a rail format value of zero means dual rail and one means single rail.
// RULE_10: in dual rail the coder is bypassed, the rails stay separate and each received pulse drives its own output.
// RULE_11: in single rail data uses the positive rails and the negative output flags line code violations.
// RULE_12: each of the three channels keeps its own copy of the bits and a read returns what was written.
package lcm_pkg;

   // register byte offsets, one word per channel
   localparam logic [7:0] CH_MODE_CTRL_BASE   = 8'h00;
   localparam logic [7:0] CH_MODE_CTRL_STRIDE = 8'h04;

   // field positions in channel_mode_control
   localparam int RAIL_FORMAT_POS  = 0;
   localparam int SONET_RATE_POS   = 1;
   localparam int E3_RATE_POS      = 2;
   localparam int LOCAL_LOOP_POS   = 3;
   localparam int REMOTE_LOOP_POS  = 4;
   localparam int CTRL_WIDTH       = 5;

   // reset value of every channel's field set
   localparam logic [4:0] CTRL_RESET = 5'h00;

   // apb answer for unmapped reads
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      LCM_LOOP_NONE,
      LCM_LOOP_REMOTE,
      LCM_LOOP_ANALOG_LOCAL,
      LCM_LOOP_DIGITAL_LOCAL
   } lcm_loop_type;

   typedef enum logic [1:0] {
      LCM_RATE_DS3,
      LCM_RATE_STS1,
      LCM_RATE_E3
   } lcm_rate_type;

   // stored control fields of one channel
   typedef struct packed {
      logic remote_loop_sel;
      logic local_loop_sel;
      logic e3_rate_sel;
      logic sonet_rate_sel;
      logic rail_format_sel;
   } lcm_ctrl_type;

   // decoded mode of one channel, driven to the datapath
   typedef struct packed {
      lcm_loop_type loop_mode;
      lcm_rate_type rate_mode;
      logic         single_rail;
      logic         coder_enable;
   } lcm_mode_type;

endpackage

/* File: core/lcm_mode_decode.sv */
// decode of one channel's control fields into loop, rate and rail modes
// assumes the fields come straight from the register bank flip-flops
`timescale 1ns/10ps
`default_nettype none

module lcm_mode_decode (
   input  wire lcm_pkg::lcm_ctrl_type ctrl,
   output lcm_pkg::lcm_mode_type      mode
);

   // purely combinational; the top registers the result
   always_comb begin
      unique case ({ctrl.local_loop_sel, ctrl.remote_loop_sel})   // see RULE_01
         2'b00: mode.loop_mode = lcm_pkg::LCM_LOOP_NONE;
         2'b01: mode.loop_mode = lcm_pkg::LCM_LOOP_REMOTE;
         2'b10: mode.loop_mode = lcm_pkg::LCM_LOOP_ANALOG_LOCAL;
         2'b11: mode.loop_mode = lcm_pkg::LCM_LOOP_DIGITAL_LOCAL;
      endcase
      // e3 wins, the sonet bit only matters when e3 is clear
      if (ctrl.e3_rate_sel) begin
         mode.rate_mode = lcm_pkg::LCM_RATE_E3;             // see RULE_03
      end else if (ctrl.sonet_rate_sel) begin
         mode.rate_mode = lcm_pkg::LCM_RATE_STS1;           // see RULE_05
      end else begin
         mode.rate_mode = lcm_pkg::LCM_RATE_DS3;            // see RULE_04
      end
      mode.single_rail  = ctrl.rail_format_sel;             // see RULE_09
      mode.coder_enable = ctrl.rail_format_sel;             // see RULE_08
   end

endmodule

`default_nettype wire

/* File: core/lcm_channel_ctrl.sv */
// apb register bank holding the mode control word of each line channel
// assumes an apb master on pclk; decoded modes feed the channel datapaths
`timescale 1ns/10ps
`default_nettype none

module lcm_channel_ctrl #(
   parameter int N_CH = 3
) (
   input  wire logic                                pclk,
   input  wire logic                                presetn,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [7:0]                          paddr,
   input  wire logic [31:0]                         pwdata,
   input  wire logic [3:0]                          pstrb,
   output logic                                     pready,
   output logic [31:0]                              prdata,
   output logic                                     pslverr,
   output lcm_pkg::lcm_mode_type [N_CH-1:0]         ch_mode
);

   // elaboration check: the address map holds at most 8 channels
   if (N_CH < 1 || N_CH > 8) begin : g_bad_n_ch
      $error("lcm_channel_ctrl: N_CH must be 1 to 8");
   end

   // whole module state in one struct
   typedef struct packed {
      lcm_pkg::lcm_ctrl_type [N_CH-1:0] ctrl;
      lcm_pkg::lcm_mode_type [N_CH-1:0] mode;
      logic                             ready;
      logic [31:0]                      rdata;
      logic                             slverr;
   } lcm_state_type;

   lcm_state_type                    state;
   lcm_state_type                    next_state;
   lcm_pkg::lcm_mode_type [N_CH-1:0] decoded;

   localparam lcm_state_type STATE_RESET = '{
      ctrl:   {N_CH{lcm_pkg::CTRL_RESET}},
      mode:   '0,
      ready:  1'b0,
      rdata:  lcm_pkg::READ_ZERO,
      slverr: 1'b0
   };

   // one decoder per channel, each on its own copy of the fields
   for (genvar c = 0; c < N_CH; c++) begin : g_ch
      lcm_mode_decode u_dec (                               // see RULE_12
         .ctrl (state.ctrl[c]),
         .mode (decoded[c])
      );
   end

   // address decode: word index relative to the base
   logic [7:0] rel_addr;
   logic [5:0] word_idx;
   logic       hit;
   assign rel_addr = paddr - lcm_pkg::CH_MODE_CTRL_BASE;
   assign word_idx = rel_addr[7:2];
   assign hit      = (paddr[1:0] == 2'b00) && (word_idx < 6'(N_CH));

   // next state: one wait-free access phase, answer in the same cycle it is sampled
   always_comb begin
      next_state        = state;
      next_state.mode   = decoded;   // mode register follows fields one cycle later
      next_state.ready  = 1'b0;
      next_state.slverr = 1'b0;
      // pready rises in the first access cycle, so the transfer ends after two cycles
      if (psel && !penable) begin
         next_state.ready  = 1'b1;
         next_state.slverr = !hit;
         next_state.rdata  = lcm_pkg::READ_ZERO;
         if (hit && !pwrite) begin
            // upper bits, including the unmodelled pattern enable, read as zero
            next_state.rdata[lcm_pkg::CTRL_WIDTH-1:0] = state.ctrl[word_idx[2:0]];  // see RULE_12
         end
      end
      // write lands at the edge where pready is sampled high
      if (psel && penable && state.ready && pwrite && hit && pstrb[0]) begin
         next_state.ctrl[word_idx[2:0]] =
            lcm_pkg::lcm_ctrl_type'(pwdata[lcm_pkg::CTRL_WIDTH-1:0]);   // see RULE_02 see RULE_06 see RULE_07
      end
   end

   // asynchronous reset puts every channel in normal, ds3, dual rail
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= STATE_RESET;                              // see RULE_02 see RULE_06
      end else begin
         state <= next_state;
      end
   end

   // outputs straight from flip-flops
   assign pready  = state.ready;
   assign prdata  = state.rdata;
   assign pslverr = state.slverr;
   assign ch_mode = state.mode;   // datapath uses coder_enable/single_rail, see RULE_10 see RULE_11

endmodule

`default_nettype wire

/* File: bench/lcm_chk.sv */
// port assertions of the channel mode register bank
// assumes binding into lcm_channel_ctrl, one pclk domain
`timescale 1ns/10ps
`default_nettype none
module lcm_chk #(parameter int N_CH = 3) (
   input wire logic                                pclk,
   input wire logic                                presetn,
   input wire logic                                psel,
   input wire logic                                penable,
   input wire logic                                pwrite,
   input wire logic [7:0]                          paddr,
   input wire logic                                pready,
   input wire logic [31:0]                         prdata,
   input wire logic                                pslverr,
   input wire lcm_pkg::lcm_mode_type [N_CH-1:0]    ch_mode
);
   // read of channel 0: stored bits are seen there, so the decode can be tied to them
   wire logic rd0 = pready && !pwrite && paddr == 8'h00 && !pslverr;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   setup_ready_a: assert property (psel && !penable |=> pready) else $error("no pready");
   ready_pulse_a: assert property (pready |=> !pready) else $error("long pready");
   unmapped_err_a:
      assert property (pready |-> pslverr == (paddr[7:2] >= N_CH || paddr[1:0] != 2'h0)) else $error("pslverr");
   upper_zero_a: assert property (pready |-> prdata[31:5] == 27'h000_0000) else $error("upper bits");
   loop_dec_a: assert property (rd0 |-> ch_mode[0].loop_mode == {prdata[3], prdata[4]}) else $error("loop");
   rate_dec_a:
      assert property (rd0 |-> ch_mode[0].rate_mode == (prdata[2] ? 2'h2 : {1'b0, prdata[1]})) else $error("rate");
   rail_dec_a:
      assert property (rd0 |-> ch_mode[0].single_rail == prdata[0] && ch_mode[0].coder_enable == prdata[0])
         else $error("rail");
   reset_mode_a: assert property ($rose(presetn) |-> ch_mode == '0) else $error("reset mode");
endmodule
bind lcm_channel_ctrl lcm_chk #(.N_CH(N_CH)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr), .ch_mode(ch_mode));
`default_nettype wire

/* File: bench/lcm_host.sv */
// host model: apb master programming the channel registers
// assumes a slave that answers with pready on pclk
`timescale 1ns/10ps
`default_nettype none
module lcm_host (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb
);
   // error flag of the last transfer, taken at the same edge as the read data
   logic err = 1'b0;
   initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
   // one transfer; starts on a fresh edge so a release is never overwritten in the same step
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench of the channel mode register bank
// assumes the host model drives apb and the checker is bound in
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic                        pclk = 1'b0;
   logic                        presetn = 1'b0;
   logic                        psel, penable, pwrite, pready, pslverr;
   logic [7:0]                  paddr;
   logic [31:0]                 pwdata, prdata, q;
   logic [3:0]                  pstrb;
   lcm_pkg::lcm_mode_type [2:0] ch_mode;
   logic [4:0]                  sh [3] = '{default: 5'h00};
   int                          n_errors = 0;
   int                          compares = 0;
   always #2.5 pclk = ~pclk;
   lcm_channel_ctrl #(.N_CH(3)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .ch_mode(ch_mode));
   lcm_host host_u (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
   // expected decode: {loop, rate, single rail, coder}, e3 wins over the sonet bit
   function automatic logic [5:0] exp_mode(input logic [4:0] b);
      return {b[3], b[4], b[2], ~b[2] & b[1], b[0], b[0]};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t read %h exp %h", $time, got, exp);
      end
   endtask
   task automatic check_err(input logic exp);
      compares++;
      if (host_u.err !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t pslverr %b exp %b", $time, host_u.err, exp);
      end
   endtask
   task automatic check_mode;
      compares++;
      if (ch_mode !== {exp_mode(sh[2]), exp_mode(sh[1]), exp_mode(sh[0])}) begin
         n_errors++;
         $display("CHECK FAILED %0t mode %h", $time, ch_mode);
      end
   endtask
   task automatic finish_test;
      if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // main sequence: reset values, every field code, ignored writes, unmapped words
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      check_mode();
      for (int c = 0; c < 3; c++) begin
         host_u.xfer(1'b0, 8'(4 * c), 32'h0000_0000, 4'hf, q);
         check(q, 32'h0000_0000);
         check_err(1'b0);
      end
      for (int v = 0; v < 32; v++) begin
         sh[v % 3] = 5'(v);
         host_u.xfer(1'b1, 8'(4 * (v % 3)), 32'hffff_ffe0 | 32'(v), 4'h1, q);
         host_u.xfer(1'b0, 8'(4 * (v % 3)), 32'h0000_0000, 4'hf, q);
         check(q, 32'(v));
         check_err(1'b0);
         check_mode();
      end
      host_u.xfer(1'b1, 8'h04, 32'h0000_001f, 4'he, q);
      host_u.xfer(1'b0, 8'h04, 32'h0000_0000, 4'hf, q);
      check(q, 32'(sh[1]));
      host_u.xfer(1'b1, 8'h0c, 32'h0000_001f, 4'hf, q);
      check_err(1'b1);
      host_u.xfer(1'b0, 8'h0c, 32'h0000_0000, 4'hf, q);
      check(q, 32'h0000_0000);
      check_err(1'b1);
      host_u.xfer(1'b0, 8'h01, 32'h0000_0000, 4'hf, q);
      check(q, 32'h0000_0000);
      check_err(1'b1);
      check_mode();
      finish_test();
   end
   // watchdog: the run needs about 220 cycles
   initial begin
      #20000;
      n_errors++;
      $display("CHECK FAILED %0t timeout", $time);
      finish_test();
   end
endmodule
`default_nettype wire
